// >>> phk_pkg.sv
// phk_pkg: register offsets, field positions and timing constants for the
// housekeeping configuration register bank.
// assumes a 20 MHz system clock; ms/us figures are converted to cycles here.
package phk_pkg;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] PHK_OFS_CFG3 = 8'h0f;
  localparam logic [7:0] PHK_OFS_CFG4 = 8'h10;
  localparam logic [7:0] PHK_OFS_CFG5 = 8'h11;
  localparam logic [7:0] PHK_OFS_CFG6 = 8'h12;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  // housekeeping_config_three
  localparam int PHK_PFS_HI = 4;
  localparam int PHK_PFS_LO = 2;
  localparam int PHK_PRD_HI = 1;
  localparam int PHK_PRD_LO = 0;
  // delay_share_softstart_config
  localparam int PHK_OWD_HI = 7;
  localparam int PHK_OWD_LO = 6;
  localparam int PHK_SHC_HI = 5;
  localparam int PHK_SHC_LO = 4;
  localparam int PHK_SSS_HI = 3;
  localparam int PHK_SSS_LO = 2;
  localparam int PHK_ADDR1_BIT = 1;
  localparam int PHK_LOCK_BIT = 0;
  // protection_polarity_config
  localparam int PHK_OCMASK_BIT = 7;
  localparam int PHK_PENPOL_BIT = 6;
  localparam int PHK_CBPOL_BIT = 5;
  localparam int PHK_ZRT_BIT = 2;
  localparam int PHK_GNDDIS_BIT = 1;
  localparam int PHK_CBLATCH_BIT = 0;
  // bits 4..3 reserved, read as zero
  localparam logic [7:0] PHK_CFG5_MASK = 8'he7;
  // ridethrough period field in the neighbouring register
  localparam int PHK_RTP_HI = 4;
  localparam int PHK_RTP_LO = 3;

  localparam logic [7:0] PHK_RESET_VAL = 8'h00;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int PHK_CLK_HZ = 20000000;
  localparam int PHK_WARN_0_MS = 0;
  localparam int PHK_WARN_1_MS = 1;
  localparam int PHK_WARN_2_MS = 2;
  localparam int PHK_WARN_4_MS = 4;
  localparam int PHK_CYC_PER_MS = PHK_CLK_HZ / 1000;
  localparam int PHK_RT_US = 128;
  localparam int PHK_RT_US_CYC = PHK_RT_US * (PHK_CLK_HZ / 1000000);
  localparam int PHK_RT_S_CYC = PHK_CLK_HZ;
  localparam int PHK_ZRT_CYC = 2;
  localparam int PHK_CNT_W = 32;

  // ----------------------------------------------------------------------
  // pin function codes
  // ----------------------------------------------------------------------
  localparam logic [2:0] PHK_PF_ACOK_LO = 3'h0;
  localparam logic [2:0] PHK_PF_ACOK_HI = 3'h1;
  localparam logic [2:0] PHK_PF_POS_OV = 3'h2;
  localparam logic [2:0] PHK_PF_POS_UV = 3'h3;
  localparam logic [2:0] PHK_PF_NEG_OV = 3'h4;
  localparam logic [2:0] PHK_PF_NEG_UV = 3'h5;
  localparam logic [2:0] PHK_PF_FLAG = 3'h6;

  typedef enum logic [1:0] {
    PHK_BOOT_ADDR = 2'b00,
    PHK_BOOT_WAIT = 2'b01,
    PHK_RUN = 2'b10
  } phk_boot_t;

  // warn delay code to cycles: 00=2ms 01=0ms 10=1ms 11=4ms
  function automatic logic [PHK_CNT_W-1:0] phk_warn_cyc(input logic [1:0] code);
    case (code)
      2'b00: phk_warn_cyc = PHK_CNT_W'(PHK_WARN_2_MS * PHK_CYC_PER_MS);
      2'b01: phk_warn_cyc = PHK_CNT_W'(PHK_WARN_0_MS * PHK_CYC_PER_MS);
      2'b10: phk_warn_cyc = PHK_CNT_W'(PHK_WARN_1_MS * PHK_CYC_PER_MS);
      default: phk_warn_cyc = PHK_CNT_W'(PHK_WARN_4_MS * PHK_CYC_PER_MS);
    endcase
  endfunction : phk_warn_cyc

endpackage : phk_pkg

// >>> phk_delay.sv
// phk_delay: programmable delay counter; done rises load plus one cycles after start.
// assumes start is a level held high for as long as the delay should run.
`timescale 1ns/1ps
module phk_delay
  import phk_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic start,
  input wire logic [PHK_CNT_W-1:0] load,
  // result
  output logic done
);

  logic [PHK_CNT_W-1:0] cnt_reg;
  logic [PHK_CNT_W-1:0] cnt_next;
  logic done_reg;
  logic done_next;

  always_comb begin
    cnt_next = cnt_reg;
    done_next = 1'b0;
    if (!start) begin
      cnt_next = '0;
    end else if (cnt_reg >= load) begin
      done_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + PHK_CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign done = done_reg;

endmodule : phk_delay

// >>> phk_regs.sv
// phk_regs: housekeeping configuration registers with EEPROM shadow load,
// trim lock, overcurrent masking/ridethrough, polarity and breaker latch.
// assumes an SMBus slave front end presents byte writes and reads with
// one-cycle strobes, and an EEPROM reader answering one byte per request.
`timescale 1ns/1ps
module phk_regs
  import phk_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // smbus register access
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic wr_rejected,
  // eeprom shadow load
  input wire logic reload_req,
  output logic ee_req,
  output logic [7:0] ee_addr,
  input wire logic ee_ack,
  input wire logic [7:0] ee_data,
  output logic boot_done,
  // neighbouring register bits
  input wire logic [7:0] cfg6_value,
  input wire logic power_enable_polarity_hi,
  input wire logic breaker_polarity_hi,
  // housekeeping inputs
  input wire logic overcurrent_raw,
  input wire logic gnd_ok_in,
  input wire logic mains_good_in,
  input wire logic pin_cmp_above,
  input wire logic power_on_req,
  input wire logic breaker_clear,
  // housekeeping outputs
  output logic overcurrent_flag,
  output logic overcurrent_fault,
  output logic gnd_ok_to_debounce,
  output logic power_enable_out,
  output logic circuit_breaker_out,
  output logic pin_oe,
  output logic mains_good_out,
  output logic pin_five_flag,
  output logic pin_ov_flag,
  output logic pin_uv_flag,
  output logic power_off_warn,
  output logic [1:0] share_capture_sel,
  output logic [1:0] soft_start_step_sel,
  output logic second_address_bit,
  output logic [1:0] power_request_debounce_sel
);

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  logic [7:0] cfg3_reg, cfg3_next;
  logic [7:0] cfg4_reg, cfg4_next;
  logic [7:0] cfg5_reg, cfg5_next;
  phk_boot_t boot_reg, boot_next;
  logic [7:0] eaddr_reg, eaddr_next;
  logic [7:0] rdata_reg, rdata_next;
  logic rej_reg, rej_next;
  logic bdone_reg, bdone_next;
  logic ereq_reg, ereq_next;

  logic locked;
  logic is_trim;
  assign locked = cfg4_reg[PHK_LOCK_BIT];
  assign is_trim = (addr == PHK_OFS_CFG3) || (addr == PHK_OFS_CFG4) || (addr == PHK_OFS_CFG5);

  always_comb begin
    cfg3_next = cfg3_reg;
    cfg4_next = cfg4_reg;
    cfg5_next = cfg5_reg;
    boot_next = boot_reg;
    eaddr_next = eaddr_reg;
    rdata_next = rdata_reg;
    rej_next = 1'b0;
    unique case (boot_reg)
      PHK_BOOT_ADDR: begin
        boot_next = PHK_BOOT_WAIT;
      end
      PHK_BOOT_WAIT: begin
        if (ee_ack) begin
          // shadow copy overrides any lock: besides reset, the only path that clears it
          unique case (eaddr_reg)
            PHK_OFS_CFG3: cfg3_next = ee_data;
            PHK_OFS_CFG4: cfg4_next = ee_data;
            default: cfg5_next = ee_data & PHK_CFG5_MASK;
          endcase
          if (eaddr_reg == PHK_OFS_CFG5) begin
            boot_next = PHK_RUN;
          end else begin
            eaddr_next = eaddr_reg + 8'h01;
            boot_next = PHK_BOOT_ADDR;
          end
        end
      end
      PHK_RUN: begin
        if (reload_req) begin
          eaddr_next = PHK_OFS_CFG3;
          boot_next = PHK_BOOT_ADDR;
        end else if (wr_stb && is_trim && locked) begin
          rej_next = 1'b1;
        end else if (wr_stb) begin
          unique case (addr)
            PHK_OFS_CFG3: cfg3_next = wdata;
            PHK_OFS_CFG4: cfg4_next = wdata;
            PHK_OFS_CFG5: cfg5_next = wdata & PHK_CFG5_MASK;
            default: rej_next = 1'b1;
          endcase
        end
      end
      default: boot_next = PHK_BOOT_ADDR;
    endcase
    bdone_next = (boot_next == PHK_RUN);
    ereq_next = (boot_next == PHK_BOOT_WAIT);
    if (rd_stb) begin
      unique case (addr)
        PHK_OFS_CFG3: rdata_next = cfg3_reg;
        PHK_OFS_CFG4: rdata_next = cfg4_reg;
        PHK_OFS_CFG5: rdata_next = cfg5_reg;
        default: rdata_next = PHK_RESET_VAL;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg3_reg <= PHK_RESET_VAL;
      cfg4_reg <= PHK_RESET_VAL;
      cfg5_reg <= PHK_RESET_VAL;
      boot_reg <= PHK_BOOT_ADDR;
      eaddr_reg <= PHK_OFS_CFG3;
      rdata_reg <= PHK_RESET_VAL;
      rej_reg <= 1'b0;
      bdone_reg <= 1'b0;
      ereq_reg <= 1'b0;
    end else begin
      cfg3_reg <= cfg3_next;
      cfg4_reg <= cfg4_next;
      cfg5_reg <= cfg5_next;
      boot_reg <= boot_next;
      eaddr_reg <= eaddr_next;
      rdata_reg <= rdata_next;
      rej_reg <= rej_next;
      bdone_reg <= bdone_next;
      ereq_reg <= ereq_next;
    end
  end

  // ----------------------------------------------------------------------
  // housekeeping logic
  // ----------------------------------------------------------------------
  logic run;
  logic zero_rt;
  logic [1:0] rt_code;
  logic [PHK_CNT_W-1:0] rt_cyc, rt_step;
  logic [PHK_CNT_W-1:0] warn_cyc;
  logic rt_done;
  logic warn_done;
  assign run = (boot_reg == PHK_RUN);
  assign zero_rt = cfg5_reg[PHK_ZRT_BIT];
  assign rt_code = cfg6_value[PHK_RTP_HI:PHK_RTP_LO];
  assign warn_cyc = phk_warn_cyc(cfg4_reg[PHK_OWD_HI:PHK_OWD_LO]);

  // bit set: short steps, only a residual delay; bit clear: whole seconds
  assign rt_step = zero_rt ? PHK_CNT_W'(PHK_RT_US_CYC) : PHK_CNT_W'(PHK_RT_S_CYC);
  assign rt_cyc = rt_step * (PHK_CNT_W'(rt_code) + PHK_CNT_W'(1));

  phk_delay u_ridethrough (
    .clk(clk),
    .rstn(rstn),
    .start(overcurrent_raw && run),
    .load(rt_cyc),
    .done(rt_done)
  );
  phk_delay u_warn (
    .clk(clk),
    .rstn(rstn),
    .start(!power_on_req && run),
    .load(warn_cyc),
    .done(warn_done)
  );

  logic oc_flag_reg, oc_flag_next;
  logic oc_fault_reg, oc_fault_next;
  logic gnd_reg, gnd_next;
  logic cb_state_reg, cb_state_next;
  logic pen_reg, pen_next;
  logic cb_reg, cb_next;
  logic pin_oe_reg, pin_oe_next;
  logic mg_reg, mg_next;
  logic pf_reg, pf_next;
  logic ov_reg, ov_next;
  logic uv_reg, uv_next;
  logic warn_reg, warn_next;
  logic [2:0] pfs;
  assign pfs = cfg3_reg[PHK_PFS_HI:PHK_PFS_LO];

  always_comb begin
    oc_flag_next = rt_done;
    oc_fault_next = rt_done && !cfg5_reg[PHK_OCMASK_BIT];
    gnd_next = gnd_ok_in || cfg5_reg[PHK_GNDDIS_BIT];
    cb_state_next = oc_fault_next || (cfg5_reg[PHK_CBLATCH_BIT] && cb_state_reg
                    && !breaker_clear);
    pen_next = (power_on_req && !oc_fault_next) ^ cfg5_reg[PHK_PENPOL_BIT]
               ^ power_enable_polarity_hi;
    cb_next = cb_state_next ^ cfg5_reg[PHK_CBPOL_BIT] ^ breaker_polarity_hi;
    warn_next = warn_done;
    pin_oe_next = (pfs == PHK_PF_ACOK_LO) || (pfs == PHK_PF_ACOK_HI);
    mg_next = mains_good_in ^ (pfs == PHK_PF_ACOK_LO);
    pf_next = (pfs >= PHK_PF_POS_OV) && (pfs <= PHK_PF_FLAG) && pin_cmp_above;
    ov_next = ((pfs == PHK_PF_POS_OV) && pin_cmp_above)
              || ((pfs == PHK_PF_NEG_OV) && !pin_cmp_above);
    uv_next = ((pfs == PHK_PF_POS_UV) && !pin_cmp_above)
              || ((pfs == PHK_PF_NEG_UV) && pin_cmp_above);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      oc_flag_reg <= 1'b0;
      oc_fault_reg <= 1'b0;
      gnd_reg <= 1'b0;
      cb_state_reg <= 1'b0;
      pen_reg <= 1'b0;
      cb_reg <= 1'b0;
      pin_oe_reg <= 1'b0;
      mg_reg <= 1'b0;
      pf_reg <= 1'b0;
      ov_reg <= 1'b0;
      uv_reg <= 1'b0;
      warn_reg <= 1'b0;
    end else begin
      oc_flag_reg <= oc_flag_next;
      oc_fault_reg <= oc_fault_next;
      gnd_reg <= gnd_next;
      cb_state_reg <= cb_state_next;
      pen_reg <= pen_next;
      cb_reg <= cb_next;
      pin_oe_reg <= pin_oe_next;
      mg_reg <= mg_next;
      pf_reg <= pf_next;
      ov_reg <= ov_next;
      uv_reg <= uv_next;
      warn_reg <= warn_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign rdata = rdata_reg;
  assign wr_rejected = rej_reg;
  assign ee_req = ereq_reg;
  assign ee_addr = eaddr_reg;
  assign boot_done = bdone_reg;
  assign overcurrent_flag = oc_flag_reg;
  assign overcurrent_fault = oc_fault_reg;
  assign gnd_ok_to_debounce = gnd_reg;
  assign power_enable_out = pen_reg;
  assign circuit_breaker_out = cb_reg;
  assign pin_oe = pin_oe_reg;
  assign mains_good_out = mg_reg;
  assign pin_five_flag = pf_reg;
  assign pin_ov_flag = ov_reg;
  assign pin_uv_flag = uv_reg;
  assign power_off_warn = warn_reg;
  assign share_capture_sel = cfg4_reg[PHK_SHC_HI:PHK_SHC_LO];
  assign soft_start_step_sel = cfg4_reg[PHK_SSS_HI:PHK_SSS_LO];
  assign second_address_bit = cfg4_reg[PHK_ADDR1_BIT];
  assign power_request_debounce_sel = cfg3_reg[PHK_PRD_HI:PHK_PRD_LO];

endmodule : phk_regs

// >>> phk_ee_model.sv
// phk_ee_model: shadow store answering the bank's load requests.
// assumes one request at a time on ee_req/ee_addr, answered by a one-cycle ack.
`timescale 1ns/1ps
module phk_ee_model
  import phk_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // load port
  input wire logic ee_req,
  input wire logic [7:0] ee_addr,
  output logic ee_ack,
  output logic [7:0] ee_data,
  // test control
  input wire logic lock_erased,
  input wire logic slow
);
  logic [2:0] wait_cnt;

  function automatic logic [7:0] image(input logic [7:0] a);
    case (a)
      PHK_OFS_CFG3: image = 8'h05;
      PHK_OFS_CFG4: image = {7'h30, ~lock_erased};
      PHK_OFS_CFG5: image = 8'hff;
      default: image = 8'h00;
    endcase
  endfunction : image

  // data toggles between answers so a stale byte never looks valid
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ee_ack <= 1'b0;
      ee_data <= 8'h5a;
      wait_cnt <= 3'h0;
    end else begin
      ee_ack <= 1'b0;
      ee_data <= ~ee_data;
      if (ee_req && !ee_ack) begin
        if (slow && wait_cnt != 3'h5) begin
          wait_cnt <= wait_cnt + 3'h1;
        end else begin
          ee_ack <= 1'b1;
          ee_data <= image(ee_addr);
          wait_cnt <= 3'h0;
        end
      end
    end
  end
endmodule : phk_ee_model

// >>> phk_regs_chk.sv
// phk_regs_chk: port-level checks of the housekeeping register bank.
// assumes it is bound to phk_regs and sees only its ports.
`timescale 1ns/1ps
module phk_regs_chk
  import phk_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register access
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [7:0] addr,
  input wire logic [7:0] rdata,
  input wire logic wr_rejected,
  input wire logic reload_req,
  // shadow load
  input wire logic ee_req,
  input wire logic [7:0] ee_addr,
  input wire logic ee_ack,
  input wire logic boot_done,
  // outputs
  input wire logic [1:0] share_capture_sel,
  input wire logic pin_ov_flag,
  input wire logic pin_uv_flag
);
  logic cfg4_wr;
  assign cfg4_wr = wr_stb && addr == PHK_OFS_CFG4;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_last_ack;
    ee_req && ee_ack && ee_addr == PHK_OFS_CFG5;
  endsequence
  sequence s_done;
    ##[1:2] boot_done;
  endsequence

  chk_boot_ends: assert property (s_last_ack |-> s_done)
    else $error("bank not ready after last load");
  chk_boot_quiet: assert property ($rose(ee_req) |-> !boot_done)
    else $error("load request while ready");
  chk_unmapped_refused: assert property (wr_stb && boot_done && !reload_req
      && (addr < PHK_OFS_CFG3 || addr > PHK_OFS_CFG5) |=> wr_rejected)
    else $error("unmapped write not refused");
  chk_reject_cause: assert property (wr_rejected |-> $past(wr_stb) && $past(boot_done))
    else $error("refusal without write");
  chk_reserved_zero: assert property (rd_stb && addr == PHK_OFS_CFG5 |=> rdata[4:3] == 2'b00)
    else $error("reserved bits not zero");
  chk_rdata_hold: assert property (!rd_stb |=> $stable(rdata))
    else $error("read data moved without read");
  chk_share_cause: assert property (!$stable(share_capture_sel) |->
      $past(ee_ack) || $past(ee_ack, 2) || $past(cfg4_wr) || $past(cfg4_wr, 2))
    else $error("share field moved without cause");
  chk_pin_flags_excl: assert property (pin_ov_flag |-> !pin_uv_flag)
    else $error("both pin flags set");
endmodule : phk_regs_chk

// >>> testbench.sv
// testbench: self-checking bench for the housekeeping register bank.
// assumes phk_regs with the shadow store model on its load port.
`timescale 1ns/1ps
module testbench;
  import phk_pkg::*;
  logic clk, rstn, wr_stb, rd_stb, wr_rejected, reload_req, ee_req, ee_ack, boot_done;
  logic [7:0] addr, wdata, rdata, ee_addr, ee_data, cfg6_value, rv;
  logic power_enable_polarity_hi, breaker_polarity_hi, overcurrent_raw, gnd_ok_in;
  logic mains_good_in, pin_cmp_above, power_on_req, breaker_clear, overcurrent_flag;
  logic overcurrent_fault, gnd_ok_to_debounce, power_enable_out, circuit_breaker_out;
  logic mains_good_out, pin_five_flag, pin_ov_flag, pin_uv_flag, power_off_warn;
  logic second_address_bit, rej, lock_erased, slow, s0, s1, pin_oe;
  logic [1:0] share_capture_sel, soft_start_step_sel, power_request_debounce_sel;
  int mismatches, num_checks;

  phk_regs i_phk_regs (
    .clk, .rstn, .wr_stb, .rd_stb, .addr, .wdata, .rdata, .wr_rejected, .reload_req,
    .ee_req, .ee_addr, .ee_ack, .ee_data, .boot_done, .cfg6_value, .power_enable_polarity_hi,
    .breaker_polarity_hi, .overcurrent_raw, .gnd_ok_in, .mains_good_in, .pin_cmp_above,
    .power_on_req, .breaker_clear, .overcurrent_flag, .overcurrent_fault, .gnd_ok_to_debounce,
    .power_enable_out, .circuit_breaker_out, .pin_oe, .mains_good_out, .pin_five_flag,
    .pin_ov_flag, .pin_uv_flag, .power_off_warn, .share_capture_sel, .soft_start_step_sel,
    .second_address_bit, .power_request_debounce_sel
  );
  phk_ee_model i_phk_ee_model (.clk, .rstn, .ee_req, .ee_addr, .ee_ack, .ee_data,
    .lock_erased, .slow);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic bit bad(input bit c);
    num_checks++;
    return c;
  endfunction : bad

  task automatic err(input string m);
    mismatches++;
    $display("MISMATCH %0t %s", $time, m);
  endtask : err

  task automatic conclude;
    if (mismatches == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_stb <= 1'b0;
    #1 rej = wr_rejected;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 rv = rdata;
  endtask : rd

  task automatic wait_boot;
    for (int i = 0; i < 400 && boot_done !== 1'b1; i++) @(posedge clk);
    if (boot_done !== 1'b1) begin
      err("load never finished");
      conclude();
    end
  endtask : wait_boot

  // counts edges from the launching edge until the chosen output rises
  task automatic timed(input bit sel, input int lo);
    int c;
    c = 0;
    while ((sel ? overcurrent_flag : power_off_warn) !== 1'b1 && c < lo + 20) begin
      @(posedge clk);
      c++;
    end
    if (bad(c < lo || c > lo + 8)) err("delay out of range");
    if (c >= lo + 20) conclude();
  endtask : timed

  task automatic t_boot_lock;
    wait_boot();
    rd(8'h0f);
    if (bad(rv !== 8'h05)) err("cfg3 load value");
    rd(8'h11);
    if (bad(rv !== 8'he7)) err("cfg5 load value");
    if (bad(share_capture_sel !== 2'b10)) err("share field after load");
    for (int a = 8'h0f; a <= 8'h11; a++) begin
      wr(a[7:0], 8'h00);
      if (bad(rej !== 1'b1)) err("locked write taken");
    end
    rd(8'h10);
    if (bad(rv !== 8'h61)) err("locked register changed");
    wr(8'h20, 8'h55);
    if (bad(rej !== 1'b1)) err("unmapped write taken");
    rd(8'h20);
    if (bad(rv !== 8'h00)) err("unmapped read not zero");
  endtask : t_boot_lock

  task automatic t_unlock;
    @(posedge clk);
    lock_erased <= 1'b1;
    slow <= 1'b1;
    reload_req <= 1'b1;
    @(posedge clk);
    reload_req <= 1'b0;
    repeat (40) @(posedge clk);
    wait_boot();
    rd(8'h10);
    if (bad(rv !== 8'h60)) err("lock kept after reload");
    wr(8'h11, 8'h18);
    rd(8'h11);
    if (bad(rej !== 1'b0 || rv !== 8'h00)) err("reserved bits stored");
  endtask : t_unlock

  task automatic t_fields;
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      wr(8'h10, {2'b01, c, c, c[0], 1'b0});
      if (bad(share_capture_sel !== c)) err("share field");
      if (bad(soft_start_step_sel !== c)) err("soft start field");
      if (bad(second_address_bit !== c[0])) err("address bit");
      wr(8'h0f, {6'h00, c});
      if (bad(power_request_debounce_sel !== c)) err("debounce field");
    end
  endtask : t_fields

  task automatic t_warn;
    logic [1:0] cd[3] = '{2'b01, 2'b10, 2'b00};
    int lo[3] = '{0, 20000, 40000};
    for (int i = 0; i < 3; i++) begin
      wr(8'h10, {cd[i], 6'h00});
      @(posedge clk);
      power_on_req <= 1'b0;
      timed(1'b0, lo[i]);
      @(posedge clk);
      power_on_req <= 1'b1;
      repeat (10) @(posedge clk);
    end
  endtask : t_warn

  task automatic t_ocp;
    wr(8'h11, 8'h84);
    @(posedge clk);
    overcurrent_raw <= 1'b1;
    timed(1'b1, 2560);
    if (bad(overcurrent_fault !== 1'b0)) err("masked fault seen");
    @(posedge clk);
    overcurrent_raw <= 1'b0;
    cfg6_value <= 8'h08;
    repeat (10) @(posedge clk);
    for (int m = 0; m < 2; m++) begin
      wr(8'h11, m ? 8'h04 : 8'h05);
      @(posedge clk);
      overcurrent_raw <= 1'b1;
      timed(1'b1, 5120);
      repeat (4) @(posedge clk);
      #1;
      if (bad(overcurrent_fault !== 1'b1)) err("fault missing");
      @(posedge clk);
      overcurrent_raw <= 1'b0;
      repeat (10) @(posedge clk);
      #1;
      if (bad(circuit_breaker_out !== (m == 0))) err("breaker latch mode");
      @(posedge clk);
      breaker_clear <= 1'b1;
      @(posedge clk);
      breaker_clear <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      if (bad(circuit_breaker_out !== 1'b0)) err("breaker not cleared");
    end
    wr(8'h11, 8'h00);
    @(posedge clk);
    overcurrent_raw <= 1'b1;
    repeat (5200) @(posedge clk);
    #1;
    if (bad(overcurrent_flag !== 1'b0)) err("seconds ridethrough too short");
    @(posedge clk);
    overcurrent_raw <= 1'b0;
    repeat (10) @(posedge clk);
  endtask : t_ocp

  task automatic t_pol_gnd_pin;
    logic [2:0] ex[5][2] = '{'{3'b000, 3'b110}, '{3'b001, 3'b100}, '{3'b010, 3'b100},
      '{3'b000, 3'b101}, '{3'b000, 3'b100}};
    s0 = power_enable_out;
    s1 = circuit_breaker_out;
    @(posedge clk);
    power_enable_polarity_hi <= 1'b1;
    breaker_polarity_hi <= 1'b1;
    gnd_ok_in <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    if (bad(power_enable_out !== ~s0)) err("enable polarity");
    if (bad(circuit_breaker_out !== ~s1)) err("breaker polarity");
    if (bad(gnd_ok_to_debounce !== 1'b0)) err("ground input not passed");
    if (bad(pin_oe !== 1'b1 || mains_good_out !== 1'b1)) err("low true mains good");
    wr(8'h11, 8'h62);
    wr(8'h0f, 8'h04);
    repeat (2) @(posedge clk);
    #1;
    if (bad(power_enable_out !== s0)) err("enable polarity pair");
    if (bad(circuit_breaker_out !== s1)) err("breaker polarity pair");
    if (bad(gnd_ok_to_debounce !== 1'b1)) err("ground input not removed");
    if (bad(pin_oe !== 1'b1 || mains_good_out !== 1'b0)) err("high true mains good");
    for (int p = 0; p < 5; p++) begin
      wr(8'h0f, {3'h0, 3'(p + 2), 2'h0});
      for (int h = 0; h < 2; h++) begin
        @(posedge clk);
        pin_cmp_above <= h[0];
        repeat (3) @(posedge clk);
        #1;
        if (bad({pin_five_flag, pin_ov_flag, pin_uv_flag} !== ex[p][h])) err("pin flags");
      end
    end
    if (bad(pin_oe !== 1'b0)) err("pin driven in comparator mode");
  endtask : t_pol_gnd_pin

  initial begin
    rstn = 1'b0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    reload_req = 1'b0;
    cfg6_value = 8'h00;
    power_enable_polarity_hi = 1'b0;
    breaker_polarity_hi = 1'b0;
    overcurrent_raw = 1'b0;
    gnd_ok_in = 1'b1;
    mains_good_in = 1'b0;
    pin_cmp_above = 1'b0;
    power_on_req = 1'b1;
    breaker_clear = 1'b0;
    lock_erased = 1'b0;
    slow = 1'b0;
    mismatches = 0;
    num_checks = 0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_boot_lock();
    t_unlock();
    t_fields();
    t_warn();
    t_ocp();
    t_pol_gnd_pin();
    conclude();
  end
endmodule : testbench

bind phk_regs phk_regs_chk i_phk_regs_chk (.clk, .rstn, .wr_stb, .rd_stb, .addr, .rdata,
  .wr_rejected, .reload_req, .ee_req, .ee_addr, .ee_ack, .boot_done, .share_capture_sel,
  .pin_ov_flag, .pin_uv_flag);
